// ---- rtl/burst_order_defs.svh ----
// constants for mode register decode and burst column sequencing
`ifndef BURST_ORDER_DEFS_SVH
`define BURST_ORDER_DEFS_SVH

`define CFG_WIDTH        14
`define CFG_BL_LSB       0
`define CFG_BL_MSB       2
`define CFG_BT_BIT       3
`define CFG_LAT_LSB      4
`define CFG_LAT_MSB      6
`define CFG_RESET        14'h0000
`define BL_CODE_2        3'h1
`define BL_CODE_4        3'h2
`define BL_CODE_8        3'h3
`define BL_CODE_16       3'h4
`define COL_WIDTH        10
`define ADDR_WIDTH       14

`endif

// ---- rtl/burst_order_pkg.sv ----
// types shared by the mode register and burst sequencer
package burst_order_pkg;

    typedef enum logic [2:0] {
        CMD_NOP       = 3'h0,
        CMD_MODE_LOAD = 3'h1,
        CMD_READ      = 3'h2,
        CMD_WRITE     = 3'h3,
        CMD_DPD_ENTRY = 3'h4,
        CMD_OTHER     = 3'h5
    } cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_BURST = 2'b01
    } seq_state_t;

    typedef struct packed {
        logic [2:0] latency;
        logic       interleaved;
        logic [2:0] burst_code;
    } mode_fields_t;

    typedef struct packed {
        logic       active;
        logic       is_write;
        logic [9:0] column;
        logic       last;
    } col_beat_t;

endpackage : burst_order_pkg

// ---- rtl/lpddr_mode_reg_burst_order.sv ----
// mode register capture and burst column order generator
// Operation
// - mode load with both bank select bits low captures settings from address bus
// - register holds until next mode load, deep sleep entry, or power loss
// - A0-A2 burst length, A3 burst type, A4-A6 read latency
// - burst length bounds columns per command; lengths 2, 4, 8
// - sequential and interleaved order both available for every length
// - burst stays in aligned block of burst length, wrapping at edge
// - block set by A1 up, A2 up, A3 up for lengths 2, 4, 8
// - optional length sixteen uses A4 up for block, A0-A3 start
// - low column bits give first column, any start position allowed
// - one burst length serves both reads and writes
// - sequential offset increments modulo burst length from start offset
// - all inputs sampled on rising edge of true clock
`timescale 1ns/1ps
`include "burst_order_defs.svh"

module lpddr_mode_reg_burst_order (
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst_b,
    // command and address from controller pins
    input  wire logic                      cs_b,
    input  wire logic                      ras_b,
    input  wire logic                      cas_b,
    input  wire logic                      we_b,
    input  wire logic                      cke,
    input  wire logic                      bank_select_bit0,
    input  wire logic                      bank_select_bit1,
    input  wire logic [`ADDR_WIDTH-1:0]    addr,
    // configuration view
    output logic [`CFG_WIDTH-1:0]          burst_latency_config,
    output logic                           config_valid,
    output logic [2:0]                     read_latency,
    output logic                           interleaved_mode,
    output logic [4:0]                     burst_beats,
    // column sequence toward array and deep sleep state flag
    output burst_order_pkg::col_beat_t     col_beat,
    output logic                           in_deepest_sleep_state
);

    // pin synchronisers, two flops before any logic
    localparam int PIN_W = 6 + `ADDR_WIDTH;
    logic [PIN_W-1:0] pin_meta_q;
    logic [PIN_W-1:0] pin_sync_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            // reset to deselect so no command is seen while the flops fill
            pin_meta_q <= {PIN_W{1'b1}};
            pin_sync_q <= {PIN_W{1'b1}};
        end else begin
            // capture on the rising edge only
            pin_meta_q <= {cs_b, ras_b, cas_b, we_b, bank_select_bit1, bank_select_bit0, addr};
            pin_sync_q <= pin_meta_q;
        end
    end

    logic                   s_cs_b;
    logic                   s_ras_b;
    logic                   s_cas_b;
    logic                   s_we_b;
    logic                   s_ba1;
    logic                   s_ba0;
    logic [`ADDR_WIDTH-1:0] s_addr;
    logic                   cke_meta_q;
    logic                   cke_sync_q;

    assign {s_cs_b, s_ras_b, s_cas_b, s_we_b, s_ba1, s_ba0, s_addr} = pin_sync_q;

    // clock enable kept apart: it only qualifies the deep sleep decode and the deep sleep exit

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cke_meta_q <= 1'b1;
            cke_sync_q <= 1'b1;
        end else begin
            cke_meta_q <= cke;
            cke_sync_q <= cke_meta_q;
        end
    end

    function automatic burst_order_pkg::cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                                         input logic cas_n, input logic we_n,
                                                         input logic ck_en);
        burst_order_pkg::cmd_t c;
        c = burst_order_pkg::CMD_NOP;
        if (!cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'b000: c = burst_order_pkg::CMD_MODE_LOAD;
                3'b101: c = burst_order_pkg::CMD_READ;
                3'b100: c = burst_order_pkg::CMD_WRITE;
                // burst terminate with clock enable high decodes to CMD_OTHER here
                3'b110: c = ck_en ? burst_order_pkg::CMD_OTHER : burst_order_pkg::CMD_DPD_ENTRY;
                3'b111: c = burst_order_pkg::CMD_NOP;
                default: c = burst_order_pkg::CMD_OTHER;
            endcase
        end
        return c;
    endfunction : decode_cmd

    // beats from the length code; reserved codes give zero beats
    function automatic logic [4:0] beats_of(input logic [2:0] code);
        logic [4:0] b;
        b = 5'h00;
        if (code == `BL_CODE_2) begin
            b = 5'h02;
        end else if (code == `BL_CODE_4) begin
            b = 5'h04;
        end else if (code == `BL_CODE_8) begin
            b = 5'h08;
        end else if (code == `BL_CODE_16) begin
            b = 5'h10;
        end
        return b;
    endfunction : beats_of

    burst_order_pkg::cmd_t cmd;
    assign cmd = decode_cmd(s_cs_b, s_ras_b, s_cas_b, s_we_b, cke_sync_q);

    // mode register
    logic [`CFG_WIDTH-1:0] cfg_q;
    logic [`CFG_WIDTH-1:0] cfg_d;
    logic                  cfg_valid_q;
    logic                  cfg_valid_d;
    logic                  sleep_q;
    logic                  sleep_d;
    // length decoded ahead of the register so burst_beats leaves a flop
    logic [4:0]            beats_q;
    logic [4:0]            beats_d;

    always_comb begin
        cfg_d       = cfg_q;
        cfg_valid_d = cfg_valid_q;
        sleep_d     = sleep_q;
        if (cmd == burst_order_pkg::CMD_MODE_LOAD && !s_ba0 && !s_ba1) begin
            cfg_d       = s_addr[`CFG_WIDTH-1:0];
            cfg_valid_d = 1'b1;
        end else if (cmd == burst_order_pkg::CMD_DPD_ENTRY) begin
            // contents lost on deepest sleep entry
            cfg_d       = `CFG_RESET;
            cfg_valid_d = 1'b0;
            sleep_d     = 1'b1;
        end
        // leaves deepest sleep once the synchronised clock enable is high again
        if (sleep_q && cke_sync_q) begin
            sleep_d = 1'b0;
        end
        beats_d = beats_of(cfg_d[`CFG_BL_MSB:`CFG_BL_LSB]);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q       <= `CFG_RESET;
            cfg_valid_q <= 1'b0;
            sleep_q     <= 1'b0;
            beats_q     <= 5'h00;
        end else begin
            cfg_q       <= cfg_d;
            cfg_valid_q <= cfg_valid_d;
            sleep_q     <= sleep_d;
            beats_q     <= beats_d;
        end
    end

    burst_order_pkg::mode_fields_t fields;
    // field split of the stored word, one driver for the whole struct
    assign fields = burst_order_pkg::mode_fields_t'(cfg_q[`CFG_LAT_MSB:`CFG_BL_LSB]);

    assign burst_latency_config   = cfg_q;
    assign config_valid           = cfg_valid_q;
    // latency is only stored; the data path outside this block applies it
    assign read_latency           = fields.latency;
    assign interleaved_mode       = fields.interleaved;
    assign burst_beats            = beats_q;
    assign in_deepest_sleep_state = sleep_q;

    // burst sequencer
    burst_order_pkg::seq_state_t state_q;
    burst_order_pkg::seq_state_t state_d;
    logic [`COL_WIDTH-1:0] base_q;
    logic [`COL_WIDTH-1:0] base_d;
    logic [3:0]            start_q;
    logic [3:0]            start_d;
    logic [3:0]            beat_q;
    logic [3:0]            beat_d;
    logic [3:0]            mask_q;
    logic [3:0]            mask_d;
    logic                  inter_q;
    logic                  inter_d;
    logic                  wr_q;
    logic                  wr_d;
    burst_order_pkg::col_beat_t beat_out_q;
    burst_order_pkg::col_beat_t beat_out_d;

    // in-block offset for beat k; sequential adds, interleaved xors
    function automatic logic [3:0] offset_of(input logic [3:0] st, input logic [3:0] k,
                                             input logic [3:0] m, input logic il);
        logic [3:0] o;
        if (il) begin
            o = st ^ k;
        end else begin
            o = 4'(st + k);    // carry out of the block is dropped by the mask
        end
        return o & m;          // wrap inside the block
    endfunction : offset_of

    // aligned block base: the column with its in-block offset bits cleared
    function automatic logic [`COL_WIDTH-1:0] block_of(input logic [`COL_WIDTH-1:0] col,
                                                       input logic [3:0]            m);
        return col & ~{6'h00, m};
    endfunction : block_of

    logic [3:0] new_mask;
    logic       start_cmd;
    assign new_mask  = 4'(burst_beats - 5'h01);
    // refused without a valid word or with a reserved length code
    // one length for both directions
    assign start_cmd = (cmd == burst_order_pkg::CMD_READ || cmd == burst_order_pkg::CMD_WRITE)
                       && cfg_valid_q && (burst_beats != 5'h00);

    always_comb begin
        logic [3:0] off;
        off        = 4'h0;
        state_d    = state_q;
        base_d     = base_q;
        start_d    = start_q;
        beat_d     = beat_q;
        mask_d     = mask_q;
        inter_d    = inter_q;
        wr_d       = wr_q;
        beat_out_d = '0;
        // a new column command interrupts any running burst
        if (start_cmd) begin
            // upper bits fix the block, low bits the start
            base_d  = block_of(s_addr[`COL_WIDTH-1:0], new_mask);
            start_d = s_addr[3:0] & new_mask;
            mask_d  = new_mask;
            inter_d = fields.interleaved;
            wr_d    = (cmd == burst_order_pkg::CMD_WRITE);
            beat_d  = 4'h1;
            state_d = (new_mask == 4'h0) ? burst_order_pkg::ST_IDLE
                                         : burst_order_pkg::ST_BURST;
            beat_out_d.active   = 1'b1;
            beat_out_d.is_write = wr_d;
            beat_out_d.column   = block_of(s_addr[`COL_WIDTH-1:0], new_mask) | {6'h00, start_d};
            beat_out_d.last     = (new_mask == 4'h0);
        end else begin
            case (state_q)
                burst_order_pkg::ST_BURST: begin
                    off = offset_of(start_q, beat_q, mask_q, inter_q);
                    beat_out_d.active   = 1'b1;
                    beat_out_d.is_write = wr_q;
                    beat_out_d.column   = base_q | {6'h00, off};
                    beat_out_d.last     = (beat_q == mask_q);
                    beat_d              = 4'(beat_q + 4'h1);
                    if (beat_q == mask_q) begin
                        state_d = burst_order_pkg::ST_IDLE;
                    end
                    // deep sleep entry abandons a burst the controller should have ended
                    if (cmd == burst_order_pkg::CMD_DPD_ENTRY) begin
                        state_d = burst_order_pkg::ST_IDLE;
                    end
                end
                default: begin
                    // idle: no beat is driven
                    state_d = burst_order_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= burst_order_pkg::ST_IDLE;
            base_q     <= '0;
            start_q    <= 4'h0;
            beat_q     <= 4'h0;
            mask_q     <= 4'h0;
            inter_q    <= 1'b0;
            wr_q       <= 1'b0;
            beat_out_q <= '0;
        end else begin
            state_q    <= state_d;
            base_q     <= base_d;
            start_q    <= start_d;
            beat_q     <= beat_d;
            mask_q     <= mask_d;
            inter_q    <= inter_d;
            wr_q       <= wr_d;
            beat_out_q <= beat_out_d;
        end
    end

    assign col_beat = beat_out_q;

endmodule : lpddr_mode_reg_burst_order

// ---- tb/lpddr_ctrl_model.sv ----
// controller-side model driving the command and address pins
`timescale 1ns/1ps
`include "burst_order_defs.svh"
module lpddr_ctrl_model (
    // clock
    input  wire logic                   clk_sys,
    // command and address pins
    output logic                        cs_b,
    output logic                        ras_b,
    output logic                        cas_b,
    output logic                        we_b,
    output logic                        cke,
    output logic                        bank_select_bit0,
    output logic                        bank_select_bit1,
    output logic [`ADDR_WIDTH-1:0]      addr
);
    initial begin
        {cs_b, ras_b, cas_b, we_b} = 4'hF;
        cke = 1'b1;
        {bank_select_bit1, bank_select_bit0} = 2'h0;
        addr = 14'h0000;
    end
    // one command cycle, then nop; caller spaces commands
    task automatic issue(input logic [3:0] p, input logic c, input logic [1:0] ba,
                         input logic [`ADDR_WIDTH-1:0] a);
        @(posedge clk_sys);
        {cs_b, ras_b, cas_b, we_b} <= p;
        cke <= c;
        {bank_select_bit1, bank_select_bit0} <= ba;
        addr <= a;
        @(posedge clk_sys);
        {cs_b, ras_b, cas_b, we_b} <= 4'h7;
        cke <= 1'b1;
        addr <= ~a; // released bus must not show a stale value
    endtask : issue
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : idle
endmodule : lpddr_ctrl_model

// ---- tb/lpddr_mode_reg_burst_order_asserts.sv ----
// concurrent checks on the mode register and column sequencer ports
`timescale 1ns/1ps
`include "burst_order_defs.svh"
module lpddr_mode_reg_burst_order_asserts (
    // clock and reset
    input wire logic                       clk_sys,
    input wire logic                       rst_b,
    // command pins
    input wire logic                       cs_b,
    input wire logic                       ras_b,
    input wire logic                       cas_b,
    input wire logic                       we_b,
    input wire logic                       cke,
    input wire logic                       bank_select_bit0,
    input wire logic                       bank_select_bit1,
    input wire logic [`ADDR_WIDTH-1:0]     addr,
    // design outputs
    input wire logic [`CFG_WIDTH-1:0]      burst_latency_config,
    input wire logic                       config_valid,
    input wire logic [2:0]                 read_latency,
    input wire logic                       interleaved_mode,
    input wire logic [4:0]                 burst_beats,
    input wire burst_order_pkg::col_beat_t col_beat,
    input wire logic                       in_deepest_sleep_state
);
    wire logic mload = !cs_b && !ras_b && !cas_b && !we_b
                       && !bank_select_bit0 && !bank_select_bit1;
    wire logic sleep = !cs_b && ras_b && cas_b && !we_b && !cke;
    wire logic chg = mload || sleep;
    wire logic [9:0] msk = 10'(burst_beats) - 10'h001;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    // beats seen so far in the running burst
    always_comb cnt_d = col_beat.last ? 5'h00 : cnt_q + 5'(col_beat.active);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // pins sampled at one edge reach the register two edges later, seen by the checks from the third
    a_load_captures: assert property (
        mload |-> ##4 burst_latency_config == $past(addr, 4) && config_valid)
        else $error("mode word not captured");
    a_hold_stable: assert property (
        !$past(chg, 3) |-> $stable(burst_latency_config))
        else $error("mode word changed without cause");
    a_sleep_clears: assert property (
        sleep |-> ##4 burst_latency_config == `CFG_RESET && !config_valid)
        else $error("deep sleep did not clear mode word");
    a_sleep_flag: assert property (
        sleep |-> ##3 in_deepest_sleep_state)
        else $error("deep sleep state not shown");
    a_sleep_exit: assert property (
        in_deepest_sleep_state && $past(cke) |=> !in_deepest_sleep_state)
        else $error("deep sleep state not left");
    a_beats_decode: assert property (
        burst_beats == (burst_latency_config[2:0] == `BL_CODE_2 ? 5'h02
                      : burst_latency_config[2:0] == `BL_CODE_4 ? 5'h04
                      : burst_latency_config[2:0] == `BL_CODE_8 ? 5'h08
                      : burst_latency_config[2:0] == `BL_CODE_16 ? 5'h10 : 5'h00))
        else $error("burst length decode wrong");
    a_fields_track: assert property (
        {read_latency, interleaved_mode} == burst_latency_config[6:3])
        else $error("latency or type field wrong");
    a_block_fixed: assert property (
        col_beat.active && !col_beat.last |=> col_beat.active
        && ((col_beat.column ^ $past(col_beat.column)) & ~msk) == 10'h000)
        else $error("burst left its block");
    a_seq_step: assert property (
        col_beat.active && !col_beat.last && !interleaved_mode
        |=> ((col_beat.column - $past(col_beat.column)) & msk) == 10'h001)
        else $error("sequential step wrong");
    a_burst_length: assert property (
        col_beat.active && col_beat.last |-> cnt_q + 5'h01 == burst_beats)
        else $error("burst beat count wrong");
endmodule : lpddr_mode_reg_burst_order_asserts
bind lpddr_mode_reg_burst_order lpddr_mode_reg_burst_order_asserts chk (
    .clk_sys, .rst_b, .cs_b, .ras_b, .cas_b, .we_b, .cke, .bank_select_bit0,
    .bank_select_bit1, .addr, .burst_latency_config, .config_valid, .read_latency,
    .interleaved_mode, .burst_beats, .col_beat, .in_deepest_sleep_state);

// ---- tb/lpddr_mode_reg_burst_order_tb_top.sv ----
// self-checking bench: mode loads, bursts of every length and type, deep sleep
`timescale 1ns/1ps
`include "burst_order_defs.svh"
module lpddr_mode_reg_burst_order_tb_top;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic cs_b, ras_b, cas_b, we_b, cke, bank_select_bit0, bank_select_bit1;
    logic [`ADDR_WIDTH-1:0] addr;
    logic [`CFG_WIDTH-1:0] burst_latency_config;
    logic config_valid, interleaved_mode, in_deepest_sleep_state;
    logic [2:0] read_latency;
    logic [4:0] burst_beats;
    burst_order_pkg::col_beat_t col_beat;
    burst_order_pkg::col_beat_t exp_q[$];
    int failures = 0;
    int checks = 0;
    always #25 clk_sys = ~clk_sys;
    lpddr_ctrl_model ctl (.clk_sys, .cs_b, .ras_b, .cas_b, .we_b, .cke, .bank_select_bit0,
        .bank_select_bit1, .addr);
    lpddr_mode_reg_burst_order uut (.clk_sys, .rst_b, .cs_b, .ras_b, .cas_b, .we_b, .cke,
        .bank_select_bit0, .bank_select_bit1, .addr, .burst_latency_config, .config_valid,
        .read_latency, .interleaved_mode, .burst_beats, .col_beat, .in_deepest_sleep_state);
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmp_beat(input burst_order_pkg::col_beat_t got,
                            input burst_order_pkg::col_beat_t exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_beat
    task automatic report_and_stop;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // banks idle here; recovery wait before the next command
    task automatic load(input logic [2:0] bl, input logic il, input logic [2:0] lat);
        logic [`ADDR_WIDTH-1:0] w;
        w = {7'h00, lat, il, bl};
        ctl.issue(4'h0, 1'b1, 2'h0, w);
        ctl.idle(4);
        cmp(burst_latency_config, w);
        cmp({read_latency, interleaved_mode, config_valid}, {lat, il, 1'b1});
    endtask : load
    task automatic burst(input logic wr, input logic [9:0] col, input int n, input logic il);
        logic [9:0] m;
        logic [9:0] off;
        m = 10'(n - 1);
        for (int k = 0; k < n; k++) begin
            off = il ? (col ^ 10'(k)) : (col + 10'(k));
            exp_q.push_back({1'b1, wr, (col & ~m) | (off & m), k == n - 1});
        end
        // any bank and any upper bits: the column order must not depend on them
        ctl.issue({3'b010, ~wr}, 1'b1, 2'($urandom), {4'($urandom), col});
        ctl.idle(n - 2);
    endtask : burst
    // any beat with no note pending is a mismatch
    always @(negedge clk_sys) if (rst_b && col_beat.active === 1'b1) begin
        if (exp_q.size() == 0) cmp_beat(col_beat, '0);
        else cmp_beat(col_beat, exp_q.pop_front());
    end
    initial begin
        logic [9:0] c;
        c = 10'($urandom(32'hB30F626B));
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        ctl.idle(2);
        cmp({burst_latency_config, config_valid}, 15'h0000);
        for (int b = 1; b <= 4; b++) begin
            for (int t = 0; t < 2; t++) begin
                load(3'(b), t[0], 3'(2 + t));
                cmp(burst_beats, 32'(2 << (b - 1)));
                repeat (3) begin
                    c = 10'($urandom);
                    burst(c[9], c, 2 << (b - 1), t[0]);
                end
                ctl.idle(20);
            end
        end
        // nonzero bank bits select another register; ours must hold
        ctl.issue(4'h0, 1'b1, 2'(1 + $urandom_range(2)), 14'h0013);
        ctl.idle(4);
        cmp(burst_latency_config, 14'h003C);
        ctl.issue(4'h6, 1'b0, 2'h0, 14'h0000);
        ctl.idle(4);
        cmp({burst_latency_config, config_valid}, 15'h0000);
        // read refused while the mode word is invalid
        ctl.issue(4'h5, 1'b1, 2'($urandom), 14'($urandom));
        ctl.idle(10);
        load(3'h2, 1'b0, 3'h3);
        burst(1'b1, 10'h3FF, 4, 1'b0);
        ctl.idle(30);
        cmp(exp_q.size(), 32'h0);
        report_and_stop();
    end
    initial begin
        #200us;
        failures++;
        report_and_stop();
    end
endmodule : lpddr_mode_reg_burst_order_tb_top
